//--- src/picr_pkg.sv
// shared constants and types of the process interface configuration bank
package picr_pkg;

  // register byte addresses on the apb bus
  localparam logic [11:0] ADDR_MODE_SELECT = 12'h0140;
  localparam logic [11:0] ADDR_RESERVED_WORD = 12'h0144;
  localparam logic [11:0] ADDR_CHIP_OPTION = 12'h0148;
  localparam logic [11:0] ADDR_LOAD_STATUS = 12'h014C;
  localparam logic [11:0] ADDR_PROC_IF_CFG = 12'h0150;

  // configuration memory load selectors
  localparam logic [1:0] LOAD_MODE_SELECT = 2'h0;
  localparam logic [1:0] LOAD_CHIP_OPTION = 2'h1;
  localparam logic [1:0] LOAD_RESERVED_WORD = 2'h2;
  localparam logic [1:0] LOAD_PROC_IF_CFG = 2'h3;

  // reset values when nothing has been loaded
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // chip option word fields
  localparam int CHIP_MI_LINK_BIT = 15;
  localparam int CHIP_ERR_LED_BIT = 14;
  localparam int CHIP_REG9_WRITE_BIT = 7;
  localparam int CHIP_RUN_LED_BIT = 6;
  localparam logic [15:0] CHIP_LIVE_MASK = 16'hC0C0;

  // interface mode select codes
  localparam logic [7:0] MODE_DIGITAL_IO = 8'h04;
  localparam logic [7:0] MODE_ALT_SPI = 8'h05;
  localparam logic [7:0] MODE_COMPAT_SPI = 8'h80;

  // digital i/o layout
  localparam int DIO_OUT_SEL_HI = 7;
  localparam int DIO_OUT_SEL_LO = 6;
  localparam int DIO_IN_SEL_HI = 5;
  localparam int DIO_IN_SEL_LO = 4;
  localparam int DIO_WD_DEFER_BIT = 3;
  localparam int DIO_BIDIR_BIT = 2;
  localparam int DIO_OV_MODE_BIT = 1;
  localparam int DIO_OV_POL_BIT = 0;

  // compatible spi layout
  localparam int SPI_EVENT_EN_BIT = 2;
  localparam int SPI_WAIT_POL_BIT = 1;
  localparam int SPI_WAIT_OD_BIT = 0;

  // alternate spi layout
  localparam int ALT_LATE_SAMPLE_BIT = 5;
  localparam int ALT_SEL_POL_BIT = 4;
  localparam int ALT_CLK_MODE_HI = 1;
  localparam int ALT_CLK_MODE_LO = 0;

  // output sample field codes
  localparam logic [1:0] OUT_CODE_END_OF_FRAME = 2'b00;
  localparam logic [1:0] OUT_CODE_RESERVED = 2'b01;
  localparam logic [1:0] OUT_CODE_FIRST_SYNC_PULSE = 2'b10;
  localparam logic [1:0] OUT_CODE_SECOND_SYNC_PULSE = 2'b11;

  // input sample field codes
  localparam logic [1:0] IN_CODE_START_OF_FRAME = 2'b00;
  localparam logic [1:0] IN_CODE_LATCH_RISE = 2'b01;
  localparam logic [1:0] IN_CODE_FIRST_SYNC_PULSE = 2'b10;

  // event at which output data is applied
  typedef enum logic [2:0] {
    PICR_OUT_END_OF_FRAME = 3'b000,
    PICR_OUT_FIRST_SYNC = 3'b001,
    PICR_OUT_SECOND_SYNC = 3'b011,
    PICR_OUT_WATCHDOG = 3'b010,
    PICR_OUT_NONE = 3'b110
  } picr_out_event_type;

  // event at which inputs are captured
  typedef enum logic [2:0] {
    PICR_IN_START_OF_FRAME = 3'b000,
    PICR_IN_LATCH_RISE = 3'b001,
    PICR_IN_FIRST_SYNC = 3'b011,
    PICR_IN_SECOND_SYNC = 3'b010,
    PICR_IN_NONE = 3'b110
  } picr_in_event_type;

endpackage

//--- src/picr_decode_if.sv
// decoded configuration carried from the field decoder to the top
`timescale 1ns/1ps
interface picr_decode_if;
  logic [7:0] mode;
  logic [7:0] cfg_byte;
  picr_pkg::picr_out_event_type out_event;
  picr_pkg::picr_in_event_type in_event;
  logic wd_reset_deferred;
  logic bidir_mode;
  logic out_valid_wd_mode;
  logic out_valid_active_low;
  logic spi_event_enable;
  logic wait_ack_active_high;
  logic wait_ack_open_drain;
  logic alt_late_sample;
  logic alt_select_active_high;
  logic [1:0] alt_clock_mode;

  modport decoder (
    input mode, cfg_byte,
    output out_event, in_event, wd_reset_deferred, bidir_mode, out_valid_wd_mode, out_valid_active_low,
    output spi_event_enable, wait_ack_active_high, wait_ack_open_drain, alt_late_sample,
    output alt_select_active_high, alt_clock_mode
  );
  modport top (
    output mode, cfg_byte,
    input out_event, in_event, wd_reset_deferred, bidir_mode, out_valid_wd_mode, out_valid_active_low,
    input spi_event_enable, wait_ack_active_high, wait_ack_open_drain, alt_late_sample,
    input alt_select_active_high, alt_clock_mode
  );
endinterface

//--- src/picr_field_decoder.sv
// mode dependent decoder of the interface configuration byte
`timescale 1ns/1ps
module picr_field_decoder (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // decoded configuration
  picr_decode_if.decoder dec
);

  // mode qualifiers: a field only means something in its own layout
  wire is_dio = (dec.mode == picr_pkg::MODE_DIGITAL_IO);
  wire is_spi = (dec.mode == picr_pkg::MODE_COMPAT_SPI);
  wire is_alt = (dec.mode == picr_pkg::MODE_ALT_SPI);
  wire [1:0] out_code = dec.cfg_byte[picr_pkg::DIO_OUT_SEL_HI:picr_pkg::DIO_OUT_SEL_LO];
  wire [1:0] in_code = dec.cfg_byte[picr_pkg::DIO_IN_SEL_HI:picr_pkg::DIO_IN_SEL_LO];
  wire ov_mode = dec.cfg_byte[picr_pkg::DIO_OV_MODE_BIT];

  // output event choice; watchdog mode overrides the sample field
  picr_pkg::picr_out_event_type out_nxt;
  always_comb begin
    out_nxt = picr_pkg::PICR_OUT_NONE;
    if (!is_dio) begin
      out_nxt = picr_pkg::PICR_OUT_NONE;
    end else if (ov_mode) begin
      out_nxt = picr_pkg::PICR_OUT_WATCHDOG;
    end else begin
      case (out_code)
        picr_pkg::OUT_CODE_END_OF_FRAME: out_nxt = picr_pkg::PICR_OUT_END_OF_FRAME;
        picr_pkg::OUT_CODE_FIRST_SYNC_PULSE: out_nxt = picr_pkg::PICR_OUT_FIRST_SYNC;
        picr_pkg::OUT_CODE_SECOND_SYNC_PULSE: out_nxt = picr_pkg::PICR_OUT_SECOND_SYNC;
        default: out_nxt = picr_pkg::PICR_OUT_NONE; // reserved code applies nothing
      endcase
    end
  end

  // input capture event choice
  picr_pkg::picr_in_event_type in_nxt;
  always_comb begin
    in_nxt = picr_pkg::PICR_IN_NONE;
    if (is_dio) begin
      case (in_code)
        picr_pkg::IN_CODE_START_OF_FRAME: in_nxt = picr_pkg::PICR_IN_START_OF_FRAME;
        picr_pkg::IN_CODE_LATCH_RISE: in_nxt = picr_pkg::PICR_IN_LATCH_RISE;
        picr_pkg::IN_CODE_FIRST_SYNC_PULSE: in_nxt = picr_pkg::PICR_IN_FIRST_SYNC;
        default: in_nxt = picr_pkg::PICR_IN_SECOND_SYNC;
      endcase
    end
  end

  // registered decode so the top outputs come from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec.out_event <= picr_pkg::PICR_OUT_NONE;
      dec.in_event <= picr_pkg::PICR_IN_NONE;
      dec.wd_reset_deferred <= 1'b0;
      dec.bidir_mode <= 1'b0;
      dec.out_valid_wd_mode <= 1'b0;
      dec.out_valid_active_low <= 1'b0;
      dec.spi_event_enable <= 1'b0;
      dec.wait_ack_active_high <= 1'b0;
      dec.wait_ack_open_drain <= 1'b0;
      dec.alt_late_sample <= 1'b0;
      dec.alt_select_active_high <= 1'b0;
      dec.alt_clock_mode <= 2'b00;
    end else begin
      dec.out_event <= out_nxt;
      dec.in_event <= in_nxt;
      dec.wd_reset_deferred <= is_dio & dec.cfg_byte[picr_pkg::DIO_WD_DEFER_BIT];
      dec.bidir_mode <= is_dio & dec.cfg_byte[picr_pkg::DIO_BIDIR_BIT];
      dec.out_valid_wd_mode <= is_dio & ov_mode;
      dec.out_valid_active_low <= is_dio & dec.cfg_byte[picr_pkg::DIO_OV_POL_BIT];
      dec.spi_event_enable <= is_spi & dec.cfg_byte[picr_pkg::SPI_EVENT_EN_BIT];
      dec.wait_ack_active_high <= is_spi & dec.cfg_byte[picr_pkg::SPI_WAIT_POL_BIT];
      dec.wait_ack_open_drain <= is_spi & dec.cfg_byte[picr_pkg::SPI_WAIT_OD_BIT];
      dec.alt_late_sample <= is_alt & dec.cfg_byte[picr_pkg::ALT_LATE_SAMPLE_BIT];
      dec.alt_select_active_high <= is_alt & dec.cfg_byte[picr_pkg::ALT_SEL_POL_BIT];
      dec.alt_clock_mode <= is_alt ? dec.cfg_byte[picr_pkg::ALT_CLK_MODE_HI:picr_pkg::ALT_CLK_MODE_LO] : 2'b00;
    end
  end

endmodule

//--- src/picr_config_regs.sv
// read-only process interface configuration bank with apb access
//
// Summary of operation
// - bit 15 reports management link detection
// - bit 7 permits management writes to register 9
// - output apply event from bits 7:6
// - output valid mode forces watchdog apply event
// - input capture event from bits 5:4
// - bit 3 defers watchdog output reset
// - bit 2 makes all pins bidirectional
// - bit 1 selects output valid pin meaning
// - bit 2 enables spi event delivery
// - bits 1:0 set wait pin polarity, driver
// - bit 5 selects alternate spi late sampling
// - byte meaning follows selected interface mode
// - fields load from memory, else zero
// - least significant byte at lowest address
// - reserved word reads zero, read-only
`timescale 1ns/1ps
module picr_config_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration memory load port
  input wire logic cfg_load_valid,
  input wire logic [1:0] cfg_load_sel,
  input wire logic [15:0] cfg_load_data,
  // chip option controls
  output logic mi_link_detect_active,
  output logic mi_reg9_write_enable,
  output logic error_led_enable,
  output logic run_led_enable,
  // digital i/o controls
  output picr_pkg::picr_out_event_type output_apply_event,
  output picr_pkg::picr_in_event_type input_capture_event,
  output logic watchdog_reset_deferred,
  output logic all_pins_bidirectional,
  output logic output_valid_strobe_is_watchdog,
  output logic output_valid_strobe_active_low,
  // compatible spi controls
  output logic application_event_request_enable,
  output logic wait_ack_active_high,
  output logic wait_ack_open_drain,
  // alternate spi controls
  output logic alt_spi_late_sample,
  output logic alt_spi_select_active_high,
  output logic [1:0] alt_spi_clock_mode
);

  // stored configuration words
  logic [7:0] mode_r;
  logic [15:0] chip_r;
  logic [15:0] reserved_r;
  logic [7:0] pcfg_r;
  logic loaded_r;

  // apb answer registers
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // decoded outputs travel from the decoder through the carrier
  picr_decode_if dec_if ();

  assign dec_if.mode = mode_r;
  assign dec_if.cfg_byte = pcfg_r;

  picr_field_decoder u_decoder (
    .pclk(pclk),
    .presetn(presetn),
    .dec(dec_if.decoder)
  );

  // load strobes per word; only the memory loader writes storage
  wire ld_mode = cfg_load_valid && (cfg_load_sel == picr_pkg::LOAD_MODE_SELECT);
  wire ld_chip = cfg_load_valid && (cfg_load_sel == picr_pkg::LOAD_CHIP_OPTION);
  wire ld_resv = cfg_load_valid && (cfg_load_sel == picr_pkg::LOAD_RESERVED_WORD);
  wire ld_pcfg = cfg_load_valid && (cfg_load_sel == picr_pkg::LOAD_PROC_IF_CFG);

  // storage: zero until the image supplies a value; the bus cannot touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= picr_pkg::RESET_BYTE;
      chip_r <= picr_pkg::RESET_WORD;
      reserved_r <= picr_pkg::RESET_WORD;
      pcfg_r <= picr_pkg::RESET_BYTE;
      loaded_r <= 1'b0;
    end else begin
      if (ld_mode) begin
        mode_r <= cfg_load_data[7:0];
      end
      if (ld_chip) begin
        chip_r <= cfg_load_data & picr_pkg::CHIP_LIVE_MASK; // reserved bits forced to zero
      end
      if (ld_resv) begin
        reserved_r <= picr_pkg::RESET_WORD;
      end
      if (ld_pcfg) begin
        pcfg_r <= cfg_load_data[7:0];
      end
      if (cfg_load_valid) begin
        loaded_r <= 1'b1;
      end
    end
  end

  // address decode; a register sits in the low bits of its aligned word
  wire hit_mode = (paddr == picr_pkg::ADDR_MODE_SELECT);
  wire hit_resv = (paddr == picr_pkg::ADDR_RESERVED_WORD);
  wire hit_chip = (paddr == picr_pkg::ADDR_CHIP_OPTION);
  wire hit_stat = (paddr == picr_pkg::ADDR_LOAD_STATUS);
  wire hit_pcfg = (paddr == picr_pkg::ADDR_PROC_IF_CFG);
  wire hit_any = hit_mode | hit_resv | hit_chip | hit_stat | hit_pcfg;

  // read mux; low byte on lane 0 keeps lowest address least significant
  wire [31:0] rd_mux = hit_mode ? {24'h00_0000, mode_r} :
                       hit_resv ? {16'h0000, reserved_r} :
                       hit_chip ? {16'h0000, chip_r} :
                       hit_stat ? {31'h0000_0000, loaded_r} :
                       hit_pcfg ? {24'h00_0000, pcfg_r} :
                       32'h0000_0000;

  // a setup cycle arms a one cycle access answer
  wire setup_phase = psel && !penable && !pready_r;

  // apb answer: ready in the first access cycle; writes complete but store nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_phase;
      pslverr_r <= setup_phase && !hit_any; // unmapped address only
      prdata_r <= (setup_phase && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // chip option controls, registered from the stored word
  logic mi_link_r;
  logic mi_reg9_r;
  logic err_led_r;
  logic run_led_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mi_link_r <= 1'b0;
      mi_reg9_r <= 1'b0;
      err_led_r <= 1'b0;
      run_led_r <= 1'b0;
    end else begin
      mi_link_r <= chip_r[picr_pkg::CHIP_MI_LINK_BIT];
      mi_reg9_r <= chip_r[picr_pkg::CHIP_REG9_WRITE_BIT];
      err_led_r <= chip_r[picr_pkg::CHIP_ERR_LED_BIT];
      run_led_r <= chip_r[picr_pkg::CHIP_RUN_LED_BIT];
    end
  end

  assign mi_link_detect_active = mi_link_r;
  assign mi_reg9_write_enable = mi_reg9_r;
  assign error_led_enable = err_led_r;
  assign run_led_enable = run_led_r;

  // mode dependent controls, each a decoder flip-flop
  assign output_apply_event = dec_if.out_event;
  assign input_capture_event = dec_if.in_event;
  assign watchdog_reset_deferred = dec_if.wd_reset_deferred;
  assign all_pins_bidirectional = dec_if.bidir_mode;
  assign output_valid_strobe_is_watchdog = dec_if.out_valid_wd_mode;
  assign output_valid_strobe_active_low = dec_if.out_valid_active_low;
  assign application_event_request_enable = dec_if.spi_event_enable;
  assign wait_ack_active_high = dec_if.wait_ack_active_high;
  assign wait_ack_open_drain = dec_if.wait_ack_open_drain;
  assign alt_spi_late_sample = dec_if.alt_late_sample;
  assign alt_spi_select_active_high = dec_if.alt_select_active_high;
  assign alt_spi_clock_mode = dec_if.alt_clock_mode;

  // pwdata and pstrb are accepted but unused: every word here is read-only
  wire unused_bus = ^{pwdata, pstrb};

endmodule

//--- tb/picr_config_regs_chk.sv
// port-level assertion checker for the configuration bank
`timescale 1ns/1ps
module picr_config_regs_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // configuration memory load
  input wire logic cfg_load_valid,
  input wire logic [1:0] cfg_load_sel,
  input wire logic [15:0] cfg_load_data,
  // decoded controls
  input wire logic mi_link_detect_active,
  input wire logic mi_reg9_write_enable,
  input wire logic [2:0] output_apply_event,
  input wire logic output_valid_strobe_is_watchdog,
  input wire logic all_pins_bidirectional,
  input wire logic application_event_request_enable,
  input wire logic alt_spi_late_sample
);
  // single domain, so clock and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_next_cycle: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_reserved_reads_zero: assert property (pready && !pwrite && paddr == 12'h144 |-> prdata == 0 && !pslverr)
    else $error("reserved word read not zero");
  a_mapped_write_ok: assert property (pready && pwrite && paddr == 12'h150 |-> !pslverr)
    else $error("write to mapped register flagged");
  a_link_bit_follows: assert property (cfg_load_valid && cfg_load_sel == 2'h1 |-> ##2
    mi_link_detect_active == $past(cfg_load_data[15], 2)) else $error("link detect bit wrong");
  a_reg9_bit_follows: assert property (cfg_load_valid && cfg_load_sel == 2'h1 |-> ##2
    mi_reg9_write_enable == $past(cfg_load_data[7], 2)) else $error("register 9 gate wrong");
  a_watchdog_overrides: assert property (output_valid_strobe_is_watchdog |->
    output_apply_event == picr_pkg::PICR_OUT_WATCHDOG) else $error("watchdog apply not forced");
  a_one_mode_owns: assert property ($onehot0({all_pins_bidirectional || output_valid_strobe_is_watchdog,
    application_event_request_enable, alt_spi_late_sample})) else $error("controls of two modes active");
  // outputs may only move two edges after a load, never from bus writes
  a_still_without_load: assert property (!$past(cfg_load_valid) && !$past(cfg_load_valid, 2) |->
    $stable({mi_link_detect_active, output_apply_event, all_pins_bidirectional, alt_spi_late_sample}))
    else $error("control changed without a load");

  c_chip_load: cover property (cfg_load_valid && cfg_load_sel == 2'h1);
  c_bus_write: cover property (pready && pwrite);
  c_bus_error: cover property (pready && pslverr);
endmodule

bind picr_config_regs picr_config_regs_chk picr_config_regs_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_load_valid(cfg_load_valid),
  .cfg_load_sel(cfg_load_sel), .cfg_load_data(cfg_load_data), .mi_link_detect_active(mi_link_detect_active),
  .mi_reg9_write_enable(mi_reg9_write_enable), .output_apply_event(output_apply_event),
  .output_valid_strobe_is_watchdog(output_valid_strobe_is_watchdog),
  .all_pins_bidirectional(all_pins_bidirectional),
  .application_event_request_enable(application_event_request_enable),
  .alt_spi_late_sample(alt_spi_late_sample)
);

//--- tb/tb.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ld_v, rs;
  logic mi_lnk, reg9, wd_def, bidir, ov_wd, ev_en, w_hi, w_od, late;
  logic err_led, run_led, ov_lo, sel_hi;
  logic [1:0] clk_md;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] ld_sel;
  logic [15:0] ld_d;
  picr_pkg::picr_out_event_type out_ev;
  picr_pkg::picr_in_event_type in_ev;
  int err_total, compares;
  picr_pkg::picr_out_event_type oexp [4] = '{picr_pkg::PICR_OUT_END_OF_FRAME, picr_pkg::PICR_OUT_NONE,
    picr_pkg::PICR_OUT_FIRST_SYNC, picr_pkg::PICR_OUT_SECOND_SYNC};
  picr_pkg::picr_in_event_type iexp [4] = '{picr_pkg::PICR_IN_START_OF_FRAME, picr_pkg::PICR_IN_LATCH_RISE,
    picr_pkg::PICR_IN_FIRST_SYNC, picr_pkg::PICR_IN_SECOND_SYNC};

  picr_config_regs picr_config_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_load_valid(ld_v), .cfg_load_sel(ld_sel), .cfg_load_data(ld_d), .mi_link_detect_active(mi_lnk),
    .mi_reg9_write_enable(reg9), .error_led_enable(err_led), .run_led_enable(run_led), .output_apply_event(out_ev),
    .input_capture_event(in_ev), .watchdog_reset_deferred(wd_def), .all_pins_bidirectional(bidir),
    .output_valid_strobe_is_watchdog(ov_wd), .output_valid_strobe_active_low(ov_lo),
    .application_event_request_enable(ev_en), .wait_ack_active_high(w_hi), .wait_ack_open_drain(w_od),
    .alt_spi_late_sample(late), .alt_spi_select_active_high(sel_hi), .alt_spi_clock_mode(clk_md)
  );

  // 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // apb transfer held until pready is sampled; an idle edge follows so psel is never set twice at once
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a missing answer ends the run through the closing report
    if (pready !== 1'b1) begin
      err_total++;
      end_of_test();
    end else begin
      rd = prdata;
      rs = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge pclk);
    end
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // one load pulse; the fourth edge reads values settled at the second
  task load(input logic [1:0] s, input logic [15:0] d);
    {ld_v, ld_sel, ld_d} <= {1'b1, s, d};
    @(posedge pclk);
    ld_v <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ld_v, ld_sel, ld_d} = '0;
    err_total = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rdchk(12'h140 + 12'(4 * i), 32'h0000_0000);
    chk(out_ev, picr_pkg::PICR_OUT_NONE);
    $display("test reset values done");
    load(2'h1, 16'hFFFF);
    chk(mi_lnk, 1'b1);
    chk(reg9, 1'b1);
    chk({err_led, run_led}, 2'h3);
    rdchk(12'h148, 32'h0000_C0C0);
    load(2'h1, 16'h8000);
    chk(reg9, 1'b0);
    chk({err_led, run_led}, 2'h0);
    rdchk(12'h148, 32'h0000_8000);
    load(2'h1, 16'h0080);
    chk(mi_lnk, 1'b0);
    chk(reg9, 1'b1);
    $display("test chip options done");
    load(2'h2, 16'hFFFF);
    rdchk(12'h144, 32'h0000_0000);
    apb(1'b1, 12'h144, 32'hFFFF_FFFF);
    chk(rs, 1'b0);
    rdchk(12'h144, 32'h0000_0000);
    apb(1'b0, 12'h200, 32'h0000_0000);
    chk(rs, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("test reserved and unmapped done");
    load(2'h0, 16'h0004);
    rdchk(12'h140, 32'h0000_0004);
    rdchk(12'h14C, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      load(2'h3, {8'h00, i[1:0], i[1:0], 4'h0});
      chk(out_ev, oexp[i]);
      chk(in_ev, iexp[i]);
    end
    load(2'h3, 16'h00CE);
    chk(out_ev, picr_pkg::PICR_OUT_WATCHDOG);
    chk({ov_wd, wd_def, bidir, ev_en, ov_lo}, 5'h1C);
    rdchk(12'h150, 32'h0000_00CE);
    apb(1'b1, 12'h150, 32'h0000_00FF);
    chk(rs, 1'b0);
    rdchk(12'h150, 32'h0000_00CE);
    load(2'h3, 16'h0001);
    chk({ov_lo, ov_wd}, 2'h2);
    chk(out_ev, picr_pkg::PICR_OUT_END_OF_FRAME);
    $display("test digital io done");
    load(2'h0, 16'h0080);
    load(2'h3, 16'h0007);
    chk({ev_en, w_hi, w_od, bidir}, 4'hE);
    chk(out_ev, picr_pkg::PICR_OUT_NONE);
    load(2'h3, 16'h0002);
    chk({ev_en, w_hi, w_od}, 3'h2);
    $display("test compatible spi done");
    load(2'h0, 16'h0005);
    load(2'h3, 16'h0033);
    chk({late, sel_hi, clk_md, ev_en}, 5'h1E);
    load(2'h3, 16'h0000);
    chk({late, sel_hi, clk_md}, 4'h0);
    $display("test alternate spi done");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(12'h150, 32'h0000_0000);
    chk(mi_lnk, 1'b0);
    chk(reg9, 1'b0);
    rdchk(12'h14C, 32'h0000_0000);
    $display("test second reset done");
    end_of_test();
  end
endmodule
